// ===== rtl/mpcl_map.vh
// mpcl_map.vh: bit positions, reset values and widths for pin control
// assumes inclusion by the pin control module only
`ifndef MPCL_MAP_VH
`define MPCL_MAP_VH
`define MPCL_CFG3_RESET_SEL   7
`define MPCL_CFG3_RRS_GPO_SEL 4
`define MPCL_CFG5_FLT_POL     4
`define MPCL_USR_IRQ_EN       4
`define MPCL_RST_BITS_HI      2
`define MPCL_RST_BITS_LO      0
`define MPCL_TRIM_W           5
`define MPCL_TRIM_RESET       5'h10
`define MPCL_SYNC_STAGES      2
`define MPCL_IN_COUNT         4
`define MPCL_PIN_RX_RATE      0
`define MPCL_PIN_TX_RATE      1
`define MPCL_PIN_TX_OFF       2
`define MPCL_PIN_TX_FAULT     3
`define MPCL_OD_DRIVE         1'b0
`define MPCL_OE_OFF           1'b0
`define MPCL_TX_RATE_RESET    1'b0
`define MPCL_TX_OFF_RESET     1'b1
`define MPCL_STATUS_RESET     1'b0
`define MPCL_SYNC_RESET       1'b0
`endif

// ===== rtl/mpcl_pin_control.v
// mpcl_pin_control.v: pin function selection, rate select and transmit
// disable combining, fault polarity and status mirroring.
// assumes host pins are sampled on clock_i; the board resolves the
// open-drain wires from the output enables; config bytes come as ports.
//
// Behaviour
// - rx rate out is pin or soft, gpo when cfg3 bit 4 set
// - rx rate pin mirrored to status
// - user bit 4 turns irq output on
// - tx off when pin or soft set
// - tx off pin mirrored to status
// - cfg5 bit 4 sets fault polarity
// - fault pin level mirrored to status
// - tx rate out is pin or soft
// - tx rate pin mirrored to status
// - five bit rx trim tap select
// - rx rate out open-drain when bit 4 clear
`timescale 1ns/1ns
`include "mpcl_map.vh"

module mpcl_pin_control #(
    parameter TRIM_W = `MPCL_TRIM_W
) (
    input  wire              clock_i,
    input  wire              srst_i,
    input  wire [7:0]        oem_config_reg3_i,
    input  wire [7:0]        oem_config_reg5_i,
    input  wire [7:0]        user_control_reg_i,
    input  wire [7:0]        reset_status_byte_i,
    input  wire              gpo_level_i,
    input  wire              soft_rx_rate_select_i,
    input  wire              soft_tx_rate_select_i,
    input  wire              soft_tx_off_i,
    input  wire              fault_i,
    input  wire              irq_n_i,
    input  wire [TRIM_W-1:0] rx_trim_tap_i,
    input  wire              rx_rate_select_in_i,
    input  wire              tx_rate_select_in_i,
    input  wire              tx_off_input_i,
    input  wire              tx_fault_pin_i,
    output reg               reset_or_general_output_pin_o,
    output reg               reset_or_general_output_pin_oe_o,
    output reg               supply_sense_or_irq_pin_o,
    output reg               supply_sense_or_irq_pin_oe_o,
    output reg               rx_rate_select_out_o,
    output reg               rx_rate_select_out_oe_o,
    output reg               tx_rate_select_out_o,
    output reg               tx_off_o,
    output reg               tx_fault_out_o,
    output reg               tx_fault_out_oe_o,
    output reg               rx_rate_select_status_o,
    output reg               tx_rate_select_status_o,
    output reg               tx_off_status_o,
    output reg               tx_fault_status_o,
    output reg [TRIM_W-1:0]  rx_trim_potentiometer_o
);

    localparam NIN = `MPCL_IN_COUNT;

    // latency: config ports and soft bits reach the pins one edge after
    // they change; host pins take three edges, two in the synchroniser
    // and one in the output register. nothing here needs long counts,
    // so the block is pure level logic with no state beyond the flops.
    // the open-drain pins only ever pull low; the board pull-ups set the
    // released level.

    // raw host pin levels gathered into one vector for the synchroniser
    wire [NIN-1:0]    raw_in;
    // second flop of each synchroniser, the only copy logic may read
    wire [NIN-1:0]    sync_q;

    // synchronised pin levels by function
    wire              rx_rs;
    wire              tx_rs;
    wire              txoff;
    wire              fltpin;

    // decoded configuration bits and requests
    wire              reset_mode;
    wire              gpo_on_rx_pin;
    wire              irq_enable;
    wire              fault_low_active;
    wire              reset_active;
    wire              fault_level;

    // next values of the pin drives
    reg               next_reset_oe;
    reg               next_irq_oe;
    reg               next_rx_rate_oe;
    reg               next_tx_rate;
    reg               next_tx_off;
    reg               next_fault_oe;

    // next values of the status mirrors and the trim tap
    reg               next_rx_rate_status;
    reg               next_tx_rate_status;
    reg               next_tx_off_status;
    reg               next_fault_status;
    reg  [TRIM_W-1:0] next_trim;

    // each pin takes its own slot of the synchroniser vector
    assign raw_in[`MPCL_PIN_RX_RATE]  = rx_rate_select_in_i;
    assign raw_in[`MPCL_PIN_TX_RATE]  = tx_rate_select_in_i;
    assign raw_in[`MPCL_PIN_TX_OFF]   = tx_off_input_i;
    assign raw_in[`MPCL_PIN_TX_FAULT] = tx_fault_pin_i;

    // two flops per pin; the first may go metastable, so nothing but
    // the second flop ever reads it
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
            reg stage_a;
            reg stage_b;
            always @(posedge clock_i) begin
                if (srst_i) begin
                    stage_a <= `MPCL_SYNC_RESET;
                    stage_b <= `MPCL_SYNC_RESET;
                end else begin
                    stage_a <= raw_in[gi];
                    stage_b <= stage_a;
                end
            end
            assign sync_q[gi] = stage_b;
        end
    endgenerate

    // two cycles of latency is the price of clean levels on slow,
    // unclocked host control lines
    assign rx_rs  = sync_q[`MPCL_PIN_RX_RATE];
    assign tx_rs  = sync_q[`MPCL_PIN_TX_RATE];
    assign txoff  = sync_q[`MPCL_PIN_TX_OFF];
    assign fltpin = sync_q[`MPCL_PIN_TX_FAULT];

    // configuration decode; these ports are static in normal use
    assign reset_mode       = oem_config_reg3_i[`MPCL_CFG3_RESET_SEL];
    assign gpo_on_rx_pin    = oem_config_reg3_i[`MPCL_CFG3_RRS_GPO_SEL];
    assign irq_enable       = user_control_reg_i[`MPCL_USR_IRQ_EN];
    assign fault_low_active = oem_config_reg5_i[`MPCL_CFG5_FLT_POL];

    // any of reset status bits 2 to 0 asks for the active-low reset; the pulse
    // width is shaped upstream, this only follows the request level
    assign reset_active =
        |reset_status_byte_i[`MPCL_RST_BITS_HI:`MPCL_RST_BITS_LO];

    // wanted wire level for a fault under the programmed polarity
    assign fault_level = fault_i ^ fault_low_active;

    // reset or gpo pin: pull low on a reset request or a low gpo
    always @* begin
        if (reset_mode) begin
            next_reset_oe = reset_active;
        end else begin
            next_reset_oe = ~gpo_level_i;
        end
    end

    // irq pin stays a released analog input until enabled; once on,
    // it only pulls low while the internal irq is active
    always @* begin
        if (irq_enable) begin
            next_irq_oe = ~irq_n_i;
        end else begin
            next_irq_oe = `MPCL_OE_OFF;
        end
    end

    // rx rate pin: open drain rate select while bit 4 is clear; it can
    // only pull low, so a high select is a released wire
    always @* begin
        if (!gpo_on_rx_pin) begin
            next_rx_rate_oe = ~(rx_rs | soft_rx_rate_select_i);
        end else begin
            next_rx_rate_oe = ~gpo_level_i;
        end
    end

    // tx rate select: plain or of pin and soft bit
    always @* begin
        next_tx_rate = tx_rs | soft_tx_rate_select_i;
    end

    // the transmitter stays off if either source asks for it
    always @* begin
        next_tx_off = txoff | soft_tx_off_i;
    end

    // open drain fault: pull low whenever the wanted level is low
    always @* begin
        next_fault_oe = ~fault_level;
    end

    // rx rate pin level for software to read back
    always @* begin
        next_rx_rate_status = rx_rs;
    end

    // tx rate pin level for software to read back
    always @* begin
        next_tx_rate_status = tx_rs;
    end

    // tx off pin level, independent of the soft disable bit
    always @* begin
        next_tx_off_status = txoff;
    end

    // fault status reads the wire itself, so a fault pulled by another
    // device on a shared line still shows up here
    always @* begin
        next_fault_status = fltpin;
    end

    // trim tap passes straight through; the pot itself is analog
    always @* begin
        next_trim = rx_trim_tap_i;
    end

    // output registers: every pin and status bit leaves from a flop, so
    // the board never sees a glitch from the decode above

    // reset or gpo pin; data is tied low, only the enable moves
    always @(posedge clock_i) begin
        if (srst_i) begin
            reset_or_general_output_pin_o    <= `MPCL_OD_DRIVE;
            reset_or_general_output_pin_oe_o <= `MPCL_OE_OFF;
        end else begin
            reset_or_general_output_pin_o    <= `MPCL_OD_DRIVE;
            reset_or_general_output_pin_oe_o <= next_reset_oe;
        end
    end

    // irq pin; released in reset so the supply sense input is free
    always @(posedge clock_i) begin
        if (srst_i) begin
            supply_sense_or_irq_pin_o    <= `MPCL_OD_DRIVE;
            supply_sense_or_irq_pin_oe_o <= `MPCL_OE_OFF;
        end else begin
            supply_sense_or_irq_pin_o    <= `MPCL_OD_DRIVE;
            supply_sense_or_irq_pin_oe_o <= next_irq_oe;
        end
    end

    // rx rate pin; released in reset, which reads as a high select
    always @(posedge clock_i) begin
        if (srst_i) begin
            rx_rate_select_out_o    <= `MPCL_OD_DRIVE;
            rx_rate_select_out_oe_o <= `MPCL_OE_OFF;
        end else begin
            rx_rate_select_out_o    <= `MPCL_OD_DRIVE;
            rx_rate_select_out_oe_o <= next_rx_rate_oe;
        end
    end

    // tx rate select; driven both ways, so it has no enable
    always @(posedge clock_i) begin
        if (srst_i) begin
            tx_rate_select_out_o <= `MPCL_TX_RATE_RESET;
        end else begin
            tx_rate_select_out_o <= next_tx_rate;
        end
    end

    // tx off is held on through reset only; the synchronisers clear in reset,
    // so for two edges after release only the soft bit keeps the laser off
    always @(posedge clock_i) begin
        if (srst_i) begin
            tx_off_o <= `MPCL_TX_OFF_RESET;
        end else begin
            tx_off_o <= next_tx_off;
        end
    end

    // fault pin; released in reset
    always @(posedge clock_i) begin
        if (srst_i) begin
            tx_fault_out_o    <= `MPCL_OD_DRIVE;
            tx_fault_out_oe_o <= `MPCL_OE_OFF;
        end else begin
            tx_fault_out_o    <= `MPCL_OD_DRIVE;
            tx_fault_out_oe_o <= next_fault_oe;
        end
    end

    // status mirrors clear in reset, then follow the synchronised pins
    always @(posedge clock_i) begin
        if (srst_i) begin
            rx_rate_select_status_o <= `MPCL_STATUS_RESET;
            tx_rate_select_status_o <= `MPCL_STATUS_RESET;
            tx_off_status_o         <= `MPCL_STATUS_RESET;
            tx_fault_status_o       <= `MPCL_STATUS_RESET;
        end else begin
            rx_rate_select_status_o <= next_rx_rate_status;
            tx_rate_select_status_o <= next_tx_rate_status;
            tx_off_status_o         <= next_tx_off_status;
            tx_fault_status_o       <= next_fault_status;
        end
    end

    // trim starts mid-scale so the measurement is ranged before loading
    always @(posedge clock_i) begin
        if (srst_i) begin
            rx_trim_potentiometer_o <= `MPCL_TRIM_RESET;
        end else begin
            rx_trim_potentiometer_o <= next_trim;
        end
    end

endmodule

// ===== testbench/mpcl_asserts.sv
// mpcl_asserts.sv: port checks for mpcl_pin_control
// assumes it is bound into that module and reuses its port names
`timescale 1ns/1ns
module mpcl_asserts #(
    parameter TRIM_W = 5
) (
    input wire              clock_i,
    input wire              srst_i,
    input wire [7:0]        oem_config_reg3_i,
    input wire [7:0]        oem_config_reg5_i,
    input wire [7:0]        user_control_reg_i,
    input wire [7:0]        reset_status_byte_i,
    input wire              gpo_level_i,
    input wire              soft_rx_rate_select_i,
    input wire              soft_tx_rate_select_i,
    input wire              soft_tx_off_i,
    input wire              fault_i,
    input wire              irq_n_i,
    input wire [TRIM_W-1:0] rx_trim_tap_i,
    input wire              rx_rate_select_in_i,
    input wire              tx_rate_select_in_i,
    input wire              tx_off_input_i,
    input wire              tx_fault_pin_i,
    input wire              reset_or_general_output_pin_oe_o,
    input wire              supply_sense_or_irq_pin_oe_o,
    input wire              rx_rate_select_out_oe_o,
    input wire              tx_rate_select_out_o,
    input wire              tx_off_o,
    input wire              tx_fault_out_oe_o,
    input wire              rx_rate_select_status_o,
    input wire              tx_rate_select_status_o,
    input wire              tx_off_status_o,
    input wire              tx_fault_status_o,
    input wire [TRIM_W-1:0] rx_trim_potentiometer_o
);
    reg  [2:0] up;
    wire       ok = up == 3'h5;
    wire [3:0] pin = {rx_rate_select_in_i, tx_rate_select_in_i,
                      tx_off_input_i, tx_fault_pin_i};
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // hold off until three-deep history no longer reaches into reset
    always @(posedge clock_i) up <= srst_i ? 3'h0 : up + {2'h0, !ok};
    AST_RST_PIN:
    assert property (ok |-> reset_or_general_output_pin_oe_o ==
        ($past(oem_config_reg3_i[7]) ? |$past(reset_status_byte_i[2:0]) :
        !$past(gpo_level_i))) else $error("reset pin enable wrong");
    AST_IRQ_PIN:
    assert property (ok |-> supply_sense_or_irq_pin_oe_o ==
        ($past(user_control_reg_i[4]) && !$past(irq_n_i))) else $error("irq");
    AST_RX_RATE:
    assert property (ok |-> rx_rate_select_out_oe_o ==
        ($past(oem_config_reg3_i[4]) ? !$past(gpo_level_i) :
        !($past(rx_rate_select_in_i, 3) || $past(soft_rx_rate_select_i))))
        else $error("rx rate pin wrong");
    AST_TX_RATE:
    assert property (ok |-> tx_rate_select_out_o == ($past(tx_rate_select_in_i,
        3) || $past(soft_tx_rate_select_i))) else $error("tx rate wrong");
    AST_TX_OFF:
    assert property (ok |-> tx_off_o == ($past(tx_off_input_i, 3) ||
        $past(soft_tx_off_i))) else $error("tx off wrong");
    AST_FAULT_POL:
    assert property (ok |-> tx_fault_out_oe_o == !($past(fault_i) ^
        $past(oem_config_reg5_i[4]))) else $error("fault polarity wrong");
    AST_STATUS:
    assert property (ok |-> {rx_rate_select_status_o, tx_rate_select_status_o,
        tx_off_status_o, tx_fault_status_o} == $past(pin, 3))
        else $error("status mirror wrong");
    AST_TRIM:
    assert property (ok |-> rx_trim_potentiometer_o == $past(rx_trim_tap_i))
        else $error("trim tap wrong");
endmodule
bind mpcl_pin_control mpcl_asserts #(.TRIM_W(TRIM_W)) chk_u (.*);

// ===== testbench/mpcl_host.sv
// mpcl_host.sv: board side of the module control pins
// assumes a pull-up on the fault wire; only the device pulls it low
`timescale 1ns/1ns
module mpcl_host (
    input  wire logic       clock_i,
    input  wire logic [2:0] req_i,
    input  wire logic       oe_i,
    output logic      [2:0] pins_o = 3'h0,
    output wire logic       fault_o
);
    // host pins move just after the edge, never on it
    always @(posedge clock_i) pins_o <= #2 req_i;
    // a released wire floats up, so it cannot hold a stale low
    assign fault_o = !oe_i;
endmodule

// ===== testbench/tb_top.sv
// tb_top.sv: random self-checking bench for mpcl_pin_control
// assumes mpcl_host on the pins and the checker bound in
`timescale 1ns/1ns
module tb_top;
    logic        clock_i = 0, srst_i = 1, gpo = 0, srx = 0, stx = 0, so = 0;
    logic        flt = 0, irqn = 1;
    logic [7:0]  c3 = 0, c5 = 0, uc = 0, rs = 0;
    logic [4:0]  tap = 0;
    logic [2:0]  req = 0, pin;
    logic [15:0] q[$], e;
    wire         ro, roe, io, ioe, rxo, rxoe, txr, txo, fo, foe, fw;
    wire  [3:0]  st;
    wire  [4:0]  tr;
    wire  [15:0] obs = {ro | io | rxo | fo, roe, ioe, rxoe, txr, txo, foe,
                        st, tr};
    int          err_count = 0, n_checks = 0;
    event        chk;
    mpcl_host host_u (.clock_i(clock_i), .req_i(req), .oe_i(foe),
        .pins_o(pin), .fault_o(fw));
    mpcl_pin_control dut_u (.clock_i(clock_i), .srst_i(srst_i),
        .oem_config_reg3_i(c3), .oem_config_reg5_i(c5),
        .user_control_reg_i(uc), .reset_status_byte_i(rs), .gpo_level_i(gpo),
        .soft_rx_rate_select_i(srx), .soft_tx_rate_select_i(stx),
        .soft_tx_off_i(so), .fault_i(flt), .irq_n_i(irqn), .rx_trim_tap_i(tap),
        .rx_rate_select_in_i(pin[2]), .tx_rate_select_in_i(pin[1]),
        .tx_off_input_i(pin[0]), .tx_fault_pin_i(fw),
        .reset_or_general_output_pin_o(ro),
        .reset_or_general_output_pin_oe_o(roe),
        .supply_sense_or_irq_pin_o(io), .supply_sense_or_irq_pin_oe_o(ioe),
        .rx_rate_select_out_o(rxo), .rx_rate_select_out_oe_o(rxoe),
        .tx_rate_select_out_o(txr), .tx_off_o(txo), .tx_fault_out_o(fo),
        .tx_fault_out_oe_o(foe), .rx_rate_select_status_o(st[3]),
        .tx_rate_select_status_o(st[2]), .tx_off_status_o(st[1]),
        .tx_fault_status_o(st[0]), .rx_trim_potentiometer_o(tr));
    initial forever #10 clock_i = !clock_i;
    // settled levels; the fault wire reads back inverted enable
    function automatic logic [15:0] expv();
        logic f;
        f = flt ^ c5[4];
        return {1'h0, (c3[7] ? |rs[2:0] : !gpo), uc[4] & !irqn,
            (c3[4] ? !gpo : !(req[2] | srx)), req[1] | stx, req[0] | so,
            !f, req, f, tap};
    endfunction
    task note(input logic [15:0] v);
        q.push_back(v);
        ->chk;
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // oldest note against what the outputs show now
    always @(chk) begin
        e = q.pop_front();
        n_checks++;
        if (e !== obs) begin
            err_count++;
            $display("[FAIL] outputs expected %h seen %h", e, obs);
        end
    end
    // random levels held six cycles, long enough for the synchronisers
    initial begin
        void'($urandom(32'h946926c3));
        repeat (12) @(posedge clock_i);
        #2 note(16'h0410);
        srst_i = 0;
        for (int i = 0; i < 300; i++) begin
            {c3, c5, uc, rs} = $urandom;
            {tap, req, gpo, srx, stx, so, flt, irqn} = 14'($urandom);
            repeat (6) @(posedge clock_i);
            #2 note(expv());
        end
        @(posedge clock_i);
        complete_run();
    end
endmodule
